// file: rtl/wwd_defs.svh
// Timing figures, derived cycle counts and field positions of the window supervisor.
// Assumes a single 10 MHz system clock.
`ifndef WWD_DEFS_SVH
`define WWD_DEFS_SVH

`define WWD_CLK_HZ 10000000
`define WWD_PWRUP_MS 8
`define WWD_IGNORE_MS 32
`define WWD_OPEN_MS 32
`define WWD_CLOSED_MS 32
`define WWD_SAMPLE_US 250
`define WWD_FILT_US 10
`define WWD_PWRUP_CYC ((`WWD_PWRUP_MS * `WWD_CLK_HZ) / 1000)
`define WWD_IGNORE_CYC ((`WWD_IGNORE_MS * `WWD_CLK_HZ) / 1000)
`define WWD_OPEN_CYC ((`WWD_OPEN_MS * `WWD_CLK_HZ) / 1000)
`define WWD_CLOSED_CYC ((`WWD_CLOSED_MS * `WWD_CLK_HZ) / 1000)
`define WWD_SAMPLE_CYC ((`WWD_SAMPLE_US * `WWD_CLK_HZ) / 1000000)
`define WWD_FILT_CYC ((`WWD_FILT_US * `WWD_CLK_HZ) / 1000000)
`define WWD_TMR_W 24
`define WWD_SAM_W 16
`define WWD_FILT_W 8
`define WWD_SYNC_W 5
`define WWD_SYNC_CORE 0
`define WWD_SYNC_IO 1
`define WWD_SYNC_TRIG 2
`define WWD_SYNC_SEL_LO 3
`define WWD_SYNC_SEL_HI 4
`define WWD_TRIG_PATTERN 4'hC
`define WWD_SYNC_RST 5'h00

`endif

// file: rtl/wwd_pkg.sv
// Types shared by the window supervisor modules.
// Assumes wwd_defs.svh is on the include path.
package wwd_pkg;
`include "wwd_defs.svh"

    typedef enum logic [2:0] {
        ST_HOLD = 3'b000,
        ST_WAIT_IO = 3'b001,
        ST_IGNORE = 3'b010,
        ST_OPEN = 3'b011,
        ST_CLOSED = 3'b100,
        ST_WD_OFF = 3'b101
    } wwd_state_e;

    typedef enum logic [1:0] {
        TM_OFF = 2'b00,
        TM_SLOW = 2'b01,
        TM_FAST = 2'b10
    } wwd_timing_e;

    typedef struct packed {
        logic [`WWD_SYNC_W-1:0] s1;
        logic [`WWD_SYNC_W-1:0] s2;
        logic [`WWD_SYNC_W-1:0] s3;
        logic [`WWD_SYNC_W-1:0] out;
    } wwd_sync_s;

    typedef struct packed {
        logic [`WWD_SAM_W-1:0] cnt;
        logic [3:0] hist;
        logic valid;
    } wwd_samp_s;

    typedef struct packed {
        wwd_state_e state;
        logic [`WWD_TMR_W-1:0] tmr;
        logic [`WWD_FILT_W-1:0] uv_cnt;
        logic reset_out;
    } wwd_main_s;

endpackage : wwd_pkg

// file: rtl/wwd_pin_sync.sv
// Three-stage synchroniser for all pin inputs of the supervisor.
// Assumes pins are asynchronous to clock; output moves only when stages 2 and 3 agree.
`timescale 1ns/1ns
`include "wwd_defs.svh"
module wwd_pin_sync (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Pins and synchronised levels
    input wire logic [`WWD_SYNC_W-1:0] pins,
    output logic [`WWD_SYNC_W-1:0] levels
);
    import wwd_pkg::*;

    wwd_sync_s q, d;
    logic [`WWD_SYNC_W-1:0] agree;

    always_comb begin
        d = q;
        d.s1 = pins;
        d.s2 = q.s1;
        d.s3 = q.s2;
        // Stage 1 feeds only stage 2; a disagreement holds the old level
        agree = ~(q.s2 ^ q.s3);
        d.out = (q.out & ~agree) | (q.s3 & agree);
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            q <= {4{`WWD_SYNC_RST}};
        end else begin
            q <= d;
        end
    end

    assign levels = q.out;

endmodule : wwd_pin_sync

// file: rtl/wwd_trig_sampler.sv
// Trigger sampler: samples the trigger level once per sample period and flags a valid edge.
// Assumes a synchronised trigger level; slow selects the stretched sample period.
`timescale 1ns/1ns
`include "wwd_defs.svh"
module wwd_trig_sampler #(
    parameter logic [`WWD_SAM_W-1:0] SAMPLE_CYC = `WWD_SAM_W'(`WWD_SAMPLE_CYC)
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Trigger level and timing
    input wire logic trig_level,
    input wire logic slow,
    // One-cycle valid trigger
    output logic trig_valid
);
    import wwd_pkg::*;

    wwd_samp_s q, d;
    logic [`WWD_SAM_W-1:0] lim;
    logic [3:0] hist_n;

    always_comb begin
        d = q;
        d.valid = 1'b0;
        lim = slow ? {SAMPLE_CYC[`WWD_SAM_W-3:0], 2'b00} : SAMPLE_CYC;
        hist_n = {q.hist[2:0], trig_level};
        if (q.cnt >= lim - `WWD_SAM_W'(1)) begin
            d.cnt = '0;
            d.hist = hist_n;
            // Two high then two low samples, oldest first
            d.valid = (hist_n == `WWD_TRIG_PATTERN);
        end else begin
            d.cnt = q.cnt + `WWD_SAM_W'(1);
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign trig_valid = q.valid;

    chk_trig_pattern: assert property (@(posedge clock) disable iff (!rst_n)
        trig_valid |-> q.hist == `WWD_TRIG_PATTERN && q.cnt == '0)
        else $error("trigger flagged without two high and two low samples");

endmodule : wwd_trig_sampler

// file: rtl/wwd_supervisor.sv
// Reset supervisor and window watchdog for a dual-rail supply.
// Assumes rail monitors and strap arrive as digital pin levels, asynchronous to clock.
//
// Summary of operation
// - Hold reset low power-up delay after core good
// - Release reset only if I/O rail good
// - Filtered rail undervoltage forces reset low
// - Timebase divided from clock, strap picks speed
// - Strap low disables watchdog entirely
// - Reset rising edge starts ignore window
// - Ignore window end enters open window
// - Valid trigger in open starts closed window
// - Trigger in closed window forces reset
// - Closed expiry starts open window, bounded length
// - Open window timeout without trigger forces reset
// - Trigger is high-high-low-low sample pattern
// - Trigger completing in open window counts correct
`timescale 1ns/1ns
`include "wwd_defs.svh"
module wwd_supervisor #(
    parameter logic [`WWD_TMR_W-1:0] PWRUP_CYC = `WWD_TMR_W'(`WWD_PWRUP_CYC),
    parameter logic [`WWD_TMR_W-1:0] IGNORE_CYC = `WWD_TMR_W'(`WWD_IGNORE_CYC),
    parameter logic [`WWD_TMR_W-1:0] OPEN_CYC = `WWD_TMR_W'(`WWD_OPEN_CYC),
    parameter logic [`WWD_TMR_W-1:0] CLOSED_CYC = `WWD_TMR_W'(`WWD_CLOSED_CYC),
    parameter logic [`WWD_SAM_W-1:0] SAMPLE_CYC = `WWD_SAM_W'(`WWD_SAMPLE_CYC)
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Rail monitor comparators, high when rail at or above threshold
    input wire logic core_rail_output_good,
    input wire logic io_rail_output_good,
    // Timing strap: 1x fast, 01 slow, 00 watchdog off
    input wire logic [1:0] timebase_select,
    // Watchdog trigger from the microcontroller
    input wire logic watchdog_trigger_in,
    // Microcontroller reset, low active
    output logic reset_out
);
    import wwd_pkg::*;

    localparam logic [`WWD_FILT_W-1:0] FILT_CYC = `WWD_FILT_W'(`WWD_FILT_CYC);

    logic [`WWD_SYNC_W-1:0] lv;
    logic core_ok;
    logic io_ok;
    logic trig_lv;
    wwd_timing_e mode;
    logic slow;
    logic trig_valid;
    wwd_main_s q, d;
    logic [`WWD_TMR_W-1:0] lim;
    logic expire;
    logic running;
    logic uv;
    logic uv_fault;
    logic wd_fault;

    wwd_pin_sync u_sync (
        .clock(clock),
        .rst_n(rst_n),
        .pins({timebase_select, watchdog_trigger_in, io_rail_output_good,
               core_rail_output_good}),
        .levels(lv)
    );

    assign core_ok = lv[`WWD_SYNC_CORE];
    assign io_ok = lv[`WWD_SYNC_IO];
    assign trig_lv = lv[`WWD_SYNC_TRIG];

    // Timing from strap; off runs the reset delay at slow timing
    always_comb begin
        if (lv[`WWD_SYNC_SEL_HI]) begin
            mode = TM_FAST;
        end else if (lv[`WWD_SYNC_SEL_LO]) begin
            mode = TM_SLOW;
        end else begin
            mode = TM_OFF;
        end
    end
    assign slow = (mode != TM_FAST);

    wwd_trig_sampler #(
        .SAMPLE_CYC(SAMPLE_CYC)
    ) u_samp (
        .clock(clock),
        .rst_n(rst_n),
        .trig_level(trig_lv),
        .slow(slow),
        .trig_valid(trig_valid)
    );

    // Window length for the current state, stretched four times in slow timing
    function automatic logic [`WWD_TMR_W-1:0] scale(input logic [`WWD_TMR_W-1:0] base,
                                                     input logic s);
        scale = s ? {base[`WWD_TMR_W-3:0], 2'b00} : base;
    endfunction : scale

    // A strap change mid-window rescales the running window at once
    always_comb begin
        case (q.state)
            ST_HOLD: lim = scale(PWRUP_CYC, slow);
            ST_IGNORE: lim = scale(IGNORE_CYC, slow);
            ST_OPEN: lim = scale(OPEN_CYC, slow);
            ST_CLOSED: lim = scale(CLOSED_CYC, slow);
            default: lim = scale(PWRUP_CYC, slow);
        endcase
    end

    // Timebase is the system clock divided down by the window counter
    assign expire = (q.tmr >= lim - `WWD_TMR_W'(1));
    assign running = q.reset_out;
    assign uv = !core_ok || !io_ok;
    // Fault only once undervoltage outlasts the filter time
    assign uv_fault = running && uv && (q.uv_cnt >= FILT_CYC);
    assign wd_fault = (q.state == ST_OPEN && !trig_valid && expire && mode != TM_OFF)
        || (q.state == ST_CLOSED && trig_valid && mode != TM_OFF);

    always_comb begin
        d = q;
        d.tmr = q.tmr + `WWD_TMR_W'(1);
        // Filter counts only a continuous undervoltage; any good sample restarts it
        if (running && uv) begin
            d.uv_cnt = (q.uv_cnt >= FILT_CYC) ? q.uv_cnt : q.uv_cnt + `WWD_FILT_W'(1);
        end else begin
            d.uv_cnt = '0;
        end
        case (q.state)
            ST_HOLD: begin
                d.reset_out = 1'b0;
                if (!core_ok) begin
                    d.tmr = '0;
                end else if (expire) begin
                    d.state = ST_WAIT_IO;
                    d.tmr = '0;
                end
            end
            ST_WAIT_IO: begin
                d.tmr = '0;
                if (!core_ok) begin
                    d.state = ST_HOLD;
                end else if (io_ok) begin
                    d.reset_out = 1'b1;
                    d.state = (mode == TM_OFF) ? ST_WD_OFF : ST_IGNORE;
                end
            end
            ST_IGNORE: begin
                // Trigger is not looked at here
                if (mode == TM_OFF) begin
                    d.state = ST_WD_OFF;
                end else if (expire) begin
                    d.state = ST_OPEN;
                    d.tmr = '0;
                end
            end
            ST_OPEN: begin
                if (mode == TM_OFF) begin
                    d.state = ST_WD_OFF;
                end else if (trig_valid) begin
                    // Judged on the last sample, so a pattern begun in closed is fine
                    d.state = ST_CLOSED;
                    d.tmr = '0;
                end else if (expire) begin
                    d.state = ST_HOLD;
                    d.reset_out = 1'b0;
                    d.tmr = '0;
                end
            end
            ST_CLOSED: begin
                if (mode == TM_OFF) begin
                    d.state = ST_WD_OFF;
                end else if (trig_valid) begin
                    d.state = ST_HOLD;
                    d.reset_out = 1'b0;
                    d.tmr = '0;
                end else if (expire) begin
                    d.state = ST_OPEN;
                    d.tmr = '0;
                end
            end
            ST_WD_OFF: begin
                d.tmr = '0;
                // Strap re-enabled while running: restart from the ignore window
                if (mode != TM_OFF) begin
                    d.state = ST_IGNORE;
                end
            end
            default: begin
                d.state = ST_HOLD;
                d.reset_out = 1'b0;
                d.tmr = '0;
            end
        endcase
        // Filtered undervoltage resets land in hold too, rerunning the full delay
        if (uv_fault) begin
            d.state = ST_HOLD;
            d.reset_out = 1'b0;
            d.tmr = '0;
            d.uv_cnt = '0;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            q <= '{state: ST_HOLD, tmr: '0, uv_cnt: '0, reset_out: 1'b0};
        end else begin
            q <= d;
        end
    end

    // Push-pull model of the pulled-up reset pin
    assign reset_out = q.reset_out;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);

    sequence s_released;
        $rose(reset_out);
    endsequence

    sequence s_wd_fault;
        wd_fault && !uv_fault;
    endsequence

    chk_hold_low: assert property (q.state == ST_HOLD |-> !reset_out)
        else $error("reset high during power-up hold");

    chk_hold_delay: assert property (
        (q.state == ST_HOLD && !core_ok) |=> q.tmr == '0 && !reset_out)
        else $error("hold delay not restarted while core rail low");

    chk_release_io: assert property (
        s_released |-> $past(io_ok) && $past(core_ok) && $past(q.state) == ST_WAIT_IO)
        else $error("reset released without both rails good");

    chk_wait_io_hold: assert property (
        (q.state == ST_WAIT_IO && core_ok && !io_ok) |=> q.state == ST_WAIT_IO && !reset_out)
        else $error("reset released while I/O rail low");

    chk_uv_filter: assert property (
        (running && uv && q.uv_cnt < FILT_CYC && !wd_fault) |=> reset_out)
        else $error("short undervoltage caused a reset");

    chk_uv_fault: assert property (uv_fault |=> !reset_out ##0 q.state == ST_HOLD)
        else $error("filtered undervoltage did not reset");

    chk_off_no_wd: assert property (mode == TM_OFF |-> !wd_fault)
        else $error("watchdog fault while watchdog off");

    chk_off_stays: assert property (
        (q.state == ST_WD_OFF && mode == TM_OFF && !uv_fault)
        |=> q.state == ST_WD_OFF && reset_out)
        else $error("watchdog off state left or reset dropped");

    chk_ignore_start: assert property (
        s_released |-> q.state == ST_IGNORE || q.state == ST_WD_OFF)
        else $error("reset release did not start ignore window");

    chk_ignore_trig: assert property (
        (q.state == ST_IGNORE && !expire && mode != TM_OFF && !uv_fault)
        |=> q.state == ST_IGNORE)
        else $error("ignore window left early");

    chk_ignore_end: assert property (
        (q.state == ST_IGNORE && expire && mode != TM_OFF && !uv_fault)
        |=> q.state == ST_OPEN && q.tmr == '0)
        else $error("ignore window end did not open window");

    chk_open_closed: assert property (
        (q.state == ST_OPEN && trig_valid && mode != TM_OFF && !uv_fault)
        |=> q.state == ST_CLOSED)
        else $error("valid trigger did not start closed window");

    chk_open_hold: assert property (
        (q.state == ST_OPEN && !trig_valid && !expire && mode != TM_OFF && !uv_fault)
        |=> q.state == ST_OPEN && reset_out)
        else $error("open window ended without trigger or timeout");

    chk_closed_trig: assert property (
        q.state == ST_CLOSED ##0 s_wd_fault |=> !reset_out ##0 q.state == ST_HOLD)
        else $error("premature trigger did not reset");

    chk_closed_end: assert property (
        (q.state == ST_CLOSED && expire && !trig_valid && mode != TM_OFF && !uv_fault)
        |=> q.state == ST_OPEN)
        else $error("closed window expiry did not reopen");

    chk_open_timeout: assert property (
        q.state == ST_OPEN ##0 s_wd_fault |=> !reset_out [*2])
        else $error("open window timeout did not reset");

    chk_wd_restart: assert property (
        s_wd_fault |=> q.state == ST_HOLD && q.tmr == '0)
        else $error("watchdog reset did not rerun delay");

    chk_fast_len: assert property (!slow && q.state == ST_OPEN |-> lim == OPEN_CYC)
        else $error("fast open window not at base length");

    chk_slow_scale: assert property (
        slow && q.state == ST_OPEN |-> lim == {OPEN_CYC[`WWD_TMR_W-3:0], 2'b00})
        else $error("slow timing not four times fast");

endmodule : wwd_supervisor

// file: sim/wwd_mcu_model.sv
// Microcontroller model: answers each fire request with one watchdog trigger pulse.
// Assumes fire is a one-cycle request from the bench, changed on the rising clock edge.
`timescale 1ns/1ns
module wwd_mcu_model (
    // Clock
    input wire logic clock,
    // Bench control
    input wire logic fire,
    input wire logic slow,
    // Trigger pin, idles high
    output logic trig
);
    logic trig_q = 1'b1;
    logic [7:0] low_q = 8'h00;

    // Low held three sample periods, so two low samples always land whatever the phase
    always @(posedge clock) begin
        if (fire) begin
            trig_q <= 1'b0;
            low_q <= slow ? 8'h60 : 8'h18;
        end else if (low_q > 8'h01) begin
            low_q <= low_q - 8'h01;
        end else if (low_q == 8'h01) begin
            low_q <= 8'h00;
            trig_q <= 1'b1;
        end
    end

    assign trig = trig_q;
endmodule : wwd_mcu_model

// file: sim/window_watchdog_reset_supervisor_test.sv
// Self-checking bench for the window supervisor with a microcontroller model on the trigger.
// Assumes shortened counts: delay 50, windows 200, sample period 8 clock cycles.
`timescale 1ns/1ns
module window_watchdog_reset_supervisor_test;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic core_ok = 1'b1;
    logic io_ok = 1'b1;
    logic [1:0] sel = 2'b10;
    logic fire = 1'b0;
    logic slow = 1'b0;
    logic trig;
    logic reset_out;
    int n_mismatch = 0;
    int checks = 0;

    always #50 clock = ~clock;

    wwd_supervisor #(
        .PWRUP_CYC(24'h32),
        .IGNORE_CYC(24'hC8),
        .OPEN_CYC(24'hC8),
        .CLOSED_CYC(24'hC8),
        .SAMPLE_CYC(16'h0008)
    ) wwd_supervisor_inst (
        .clock(clock),
        .rst_n(rst_n),
        .core_rail_output_good(core_ok),
        .io_rail_output_good(io_ok),
        .timebase_select(sel),
        .watchdog_trigger_in(trig),
        .reset_out(reset_out)
    );

    wwd_mcu_model wwd_mcu_model_inst (
        .clock(clock),
        .fire(fire),
        .slow(slow),
        .trig(trig)
    );

    task automatic report_and_stop;
        if (n_mismatch == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : report_and_stop

    task automatic chk(input logic seen, input logic exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    // Lands just after the edge so registered outputs have settled
    task automatic step(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : step

    task automatic expect_at(input int n, input logic e);
        step(n);
        chk(reset_out, e);
    endtask : expect_at

    task automatic fire_trig;
        @(posedge clock) fire <= 1'b1;
        @(posedge clock) fire <= 1'b0;
    endtask : fire_trig

    task automatic restart;
        @(posedge clock) rst_n <= 1'b0;
        step(2);
        @(posedge clock) rst_n <= 1'b1;
    endtask : restart

    task automatic wait_rise;
        int i;
        i = 0;
        while (reset_out !== 1'b1 && i < 400) begin
            step(1);
            i++;
        end
    endtask : wait_rise

    task automatic t_powerup;
        @(posedge clock) rst_n <= 1'b1;
        expect_at(40, 1'b0);
        expect_at(30, 1'b1);
    endtask : t_powerup

    task automatic t_io_gate;
        @(posedge clock) io_ok <= 1'b0;
        expect_at(120, 1'b0);
        expect_at(300, 1'b0);
        @(posedge clock) io_ok <= 1'b1;
        expect_at(20, 1'b1);
    endtask : t_io_gate

    // A trigger honoured in the ignore window would make the next one premature
    task automatic t_window;
        int i;
        restart();
        wait_rise();
        chk(reset_out, 1'b1);
        step(100);
        fire_trig();
        step(148);
        fire_trig();
        for (i = 0; i < 3; i++) begin
            expect_at(20, 1'b1);
            step(278);
            fire_trig();
        end
        expect_at(90, 1'b1);
        fire_trig();
        expect_at(38, 1'b0);
        expect_at(20, 1'b0);
        expect_at(40, 1'b1);
        expect_at(340, 1'b1);
        expect_at(60, 1'b0);
    endtask : t_window

    task automatic t_off;
        @(posedge clock) sel <= 2'b00;
        restart();
        expect_at(150, 1'b0);
        expect_at(110, 1'b1);
        expect_at(1500, 1'b1);
        @(posedge clock) io_ok <= 1'b0;
        step(79);
        @(posedge clock) io_ok <= 1'b1;
        expect_at(20, 1'b1);
        @(posedge clock) io_ok <= 1'b0;
        expect_at(130, 1'b0);
        @(posedge clock) io_ok <= 1'b1;
    endtask : t_off

    // Fast windows would time out well before the late checks
    task automatic t_slow;
        @(posedge clock) sel <= 2'b01;
        slow <= 1'b1;
        restart();
        expect_at(150, 1'b0);
        wait_rise();
        chk(reset_out, 1'b1);
        step(1000);
        fire_trig();
        expect_at(700, 1'b1);
        // Two highs and first low sampled in closed, second low in open
        step(118);
        fire_trig();
        expect_at(200, 1'b1);
        expect_at(1400, 1'b1);
        expect_at(100, 1'b0);
    endtask : t_slow

    initial begin
        repeat (20) @(posedge clock);
        t_powerup();
        t_io_gate();
        t_window();
        t_off();
        t_slow();
        report_and_stop();
    end

    // Whole run takes under 10000 cycles
    initial begin
        #4000000;
        n_mismatch++;
        report_and_stop();
    end
endmodule : window_watchdog_reset_supervisor_test
